// >>> core/cmpc_consts.vh
// Constants for the comparator control register block
`ifndef CMPC_CONSTS_VH
`define CMPC_CONSTS_VH
`define CMPC_ADDR_CONTROL 8'h9B
`define CMPC_PAGE_CONTROL 8'h00
`define CMPC_BIT_ENABLE 7
`define CMPC_BIT_RESULT 6
`define CMPC_BIT_RISE 5
`define CMPC_BIT_FALL 4
`define CMPC_POS_HI 3
`define CMPC_POS_LO 2
`define CMPC_NEG_HI 1
`define CMPC_NEG_LO 0
`define CMPC_RESET_CONTROL 8'h00
`define CMPC_SYNC_STAGES 2
`endif

// >>> core/cmpc_sync.v
// Two-flop synchroniser for the asynchronous comparator output
`timescale 1ns/100ps
module cmpc_sync #(
    parameter STAGES = 2
) (
    input wire ref_clk,
    input wire rst,
    input wire clk_en,
    input wire async_in,
    output wire sync_out
);
    // ***************************************************
    // Shift chain
    // ***************************************************
    reg [STAGES-1:0] chain_reg;

    // First stage feeds only the next stage; metastability stays contained
    always @(posedge ref_clk) begin
        if (rst) begin
            chain_reg <= {STAGES{1'b0}};
        end else if (clk_en) begin
            chain_reg <= {chain_reg[STAGES-2:0], async_in};
        end
    end

    assign sync_out = chain_reg[STAGES-1];
endmodule

// >>> core/cmpc_control.v
// Comparator control and status register on the special-function bus
// Timing
// The comparator pin passes two flops before any logic sees it.
// Bit 6 then lags the pin by a further edge, three edges in all.
// An edge flag sets on the edge after the synchronised result changes.
// Interrupt requests follow the next flag value, so they rise with the flag.
// The port route follows the synchronised result, one edge after it changes.
// Writes take effect on the edge that samples the strobe.
// Read data and the select pulse stand for the one cycle after the strobe.
//
// Limitations
// Edge detection runs while the comparator is off, so enabling it can
// leave stale flags; software clears them once the analog side settles.
// Pulses on the pin shorter than a clock period may be missed entirely.
// A clear and a new edge in one cycle leave the flag set; the edge wins.
// Clock enable low freezes the synchroniser too, so a pulse seen then is
// only caught if the level still differs once the clock enable returns.
`timescale 1ns/100ps
`include "cmpc_consts.vh"
module cmpc_control (
    input wire ref_clk,
    input wire rst,
    input wire clk_en,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_page,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    output reg sfr_sel,
    input wire comparator_raw,
    input wire rise_irq_mask,
    input wire fall_irq_mask,
    output reg comparator_enable,
    output reg [1:0] positive_hysteresis_sel,
    output reg [1:0] negative_hysteresis_sel,
    output reg comparator_port_out,
    output reg rise_irq_req,
    output reg fall_irq_req
);
    // ***************************************************
    // Decode
    // ***************************************************
    function hit;
        input [7:0] addr;
        input [7:0] page;
        begin
            hit = (addr == `CMPC_ADDR_CONTROL) && (page == `CMPC_PAGE_CONTROL);
        end
    endfunction

    wire sel_now = hit(sfr_addr, sfr_page);
    wire wr_hit = sfr_wr && sel_now;
    wire rd_hit = sfr_rd && sel_now;

    // ***************************************************
    // Result synchroniser and edge detection
    // ***************************************************
    wire result_sync;
    reg result_reg;
    reg rise_flag_reg;
    reg fall_flag_reg;
    reg rise_flag_next;
    reg fall_flag_next;

    cmpc_sync #(
        .STAGES(`CMPC_SYNC_STAGES)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .async_in(comparator_raw),
        .sync_out(result_sync)
    );

    wire rise_seen = result_sync & ~result_reg;
    wire fall_seen = ~result_sync & result_reg;

    // ***************************************************
    // Write fields
    // ***************************************************
    // Slices taken once so every process reads the same bit positions
    wire wr_enable_bit = sfr_wdata[`CMPC_BIT_ENABLE];
    wire wr_rise_bit = sfr_wdata[`CMPC_BIT_RISE];
    wire wr_fall_bit = sfr_wdata[`CMPC_BIT_FALL];
    wire [1:0] wr_pos_hyst = sfr_wdata[`CMPC_POS_HI:`CMPC_POS_LO];
    wire [1:0] wr_neg_hyst = sfr_wdata[`CMPC_NEG_HI:`CMPC_NEG_LO];

    // Apart from reset, a write of 0 to a flag bit is the only way to clear it
    wire rise_clear = wr_hit & ~wr_rise_bit;
    wire fall_clear = wr_hit & ~wr_fall_bit;

    // ***************************************************
    // Flag next state
    // ***************************************************
    // A new edge wins over a clearing write in the same cycle, so no edge is lost
    always @* begin
        rise_flag_next = rise_flag_reg;
        if (rise_clear) begin
            rise_flag_next = 1'b0;
        end
        if (rise_seen) begin
            rise_flag_next = 1'b1;
        end
    end

    // Same priority for the falling side
    always @* begin
        fall_flag_next = fall_flag_reg;
        if (fall_clear) begin
            fall_flag_next = 1'b0;
        end
        if (fall_seen) begin
            fall_flag_next = 1'b1;
        end
    end

    // ***************************************************
    // Register state
    // ***************************************************
    // Enable bit; edge detection keeps running while off, software clears afterwards
    always @(posedge ref_clk) begin
        if (rst) begin
            comparator_enable <= 1'b0;
        end else if (clk_en && wr_hit) begin
            comparator_enable <= wr_enable_bit;
        end
    end

    // Hysteresis codes go straight to the analog block from these flops
    always @(posedge ref_clk) begin
        if (rst) begin
            positive_hysteresis_sel <= 2'h0;
            negative_hysteresis_sel <= 2'h0;
        end else if (clk_en && wr_hit) begin
            positive_hysteresis_sel <= wr_pos_hyst;
            negative_hysteresis_sel <= wr_neg_hyst;
        end
    end

    // Result history and sticky flags; writing 1 to a flag leaves it alone
    always @(posedge ref_clk) begin
        if (rst) begin
            result_reg <= 1'b0;
            rise_flag_reg <= 1'b0;
            fall_flag_reg <= 1'b0;
        end else if (clk_en) begin
            result_reg <= result_sync;
            rise_flag_reg <= rise_flag_next;
            fall_flag_reg <= fall_flag_next;
        end
    end

    // ***************************************************
    // Read value
    // ***************************************************
    // Bit 6 comes from the result history, so writes to it have no effect
    wire [7:0] read_value;

    assign read_value[`CMPC_BIT_ENABLE] = comparator_enable;
    assign read_value[`CMPC_BIT_RESULT] = result_reg;
    assign read_value[`CMPC_BIT_RISE] = rise_flag_reg;
    assign read_value[`CMPC_BIT_FALL] = fall_flag_reg;
    assign read_value[`CMPC_POS_HI:`CMPC_POS_LO] = positive_hysteresis_sel;
    assign read_value[`CMPC_NEG_HI:`CMPC_NEG_LO] = negative_hysteresis_sel;

    // ***************************************************
    // Outputs
    // ***************************************************
    // Read data valid one cycle after the strobe; zero otherwise so a bus OR works
    always @(posedge ref_clk) begin
        if (rst) begin
            sfr_rdata <= `CMPC_RESET_CONTROL;
            sfr_sel <= 1'b0;
        end else if (clk_en) begin
            sfr_sel <= rd_hit;
            if (rd_hit) begin
                sfr_rdata <= read_value;
            end else begin
                sfr_rdata <= 8'h00;
            end
        end
    end

    // Disabled comparator shows low on the port route; synced value keeps the pin clean
    always @(posedge ref_clk) begin
        if (rst) begin
            comparator_port_out <= 1'b0;
        end else if (clk_en) begin
            comparator_port_out <= comparator_enable & result_sync;
        end
    end

    // Requests follow the next flag value, saving a cycle; masks come from outside
    always @(posedge ref_clk) begin
        if (rst) begin
            rise_irq_req <= 1'b0;
            fall_irq_req <= 1'b0;
        end else if (clk_en) begin
            rise_irq_req <= rise_flag_next & rise_irq_mask;
            fall_irq_req <= fall_flag_next & fall_irq_mask;
        end
    end
endmodule

// >>> tb/cmpc_control_checker.sv
// Port checker for the comparator control register
`timescale 1ns/100ps
module cmpc_control_checker (
    input wire ref_clk, rst, clk_en, sfr_wr, sfr_rd, sfr_sel, comparator_raw,
    input wire rise_irq_mask, fall_irq_mask, comparator_enable, comparator_port_out,
    input wire rise_irq_req, fall_irq_req,
    input wire [7:0] sfr_addr, sfr_page, sfr_wdata,
    input wire [1:0] positive_hysteresis_sel, negative_hysteresis_sel
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Hit only at the one address on page 0
    wire hit = clk_en && sfr_addr == 8'h9B && sfr_page == 8'h00;
    // No writes so a clear cannot hide the edge
    sequence s_quiet;
        (clk_en && rise_irq_mask && !sfr_wr) [*5];
    endsequence
    a_read_sel: assert property (hit && sfr_rd |=> sfr_sel)
        else $error("no select after read");
    a_enable_wr: assert property (hit && sfr_wr |=>
        comparator_enable == $past(sfr_wdata[7])) else $error("enable");
    a_pos_hyst: assert property (hit && sfr_wr |=>
        positive_hysteresis_sel == $past(sfr_wdata[3:2])) else $error("pos hyst");
    a_neg_hyst: assert property (hit && sfr_wr |=>
        negative_hysteresis_sel == $past(sfr_wdata[1:0])) else $error("neg hyst");
    a_port_low: assert property (clk_en && !comparator_enable && !(hit && sfr_wr)
        |=> !comparator_port_out) else $error("port not low");
    a_fall_mask: assert property (clk_en && !fall_irq_mask |=> !fall_irq_req)
        else $error("masked request");
    a_rise_sticky: assert property (clk_en && rise_irq_req && rise_irq_mask
        && !(hit && sfr_wr) |=> rise_irq_req) else $error("rise flag lost");
    a_fall_sticky: assert property (clk_en && fall_irq_req && fall_irq_mask
        && !(hit && sfr_wr) |=> fall_irq_req) else $error("fall flag lost");
    a_rise_edge: assert property ($rose(comparator_raw) ##0 s_quiet
        |-> rise_irq_req) else $error("rise edge missed");
endmodule

// >>> tb/cmpc_control_tb_top.sv
// Testbench for the comparator control register
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_errors++; \
    $display("mismatch %s expected %h seen %h", n, e, s); end end
module cmpc_control_tb_top;
    logic ref_clk = 0, rst = 1, clk_en = 1, sfr_wr = 0, sfr_rd = 0, comparator_raw = 0;
    logic rise_irq_mask = 1, fall_irq_mask = 0, sfr_sel, comparator_enable;
    logic comparator_port_out, rise_irq_req, fall_irq_req;
    logic [7:0] sfr_addr = 8'h00, sfr_page = 8'h00, sfr_wdata = 8'h00, sfr_rdata, v;
    logic [1:0] positive_hysteresis_sel, negative_hysteresis_sel;
    logic s;
    int n_errors = 0, comparisons = 0;
    cmpc_control cmpc_control_inst (.ref_clk, .rst, .clk_en, .sfr_addr, .sfr_page, .sfr_wr,
        .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_sel, .comparator_raw, .rise_irq_mask,
        .fall_irq_mask, .comparator_enable, .positive_hysteresis_sel,
        .negative_hysteresis_sel, .comparator_port_out, .rise_irq_req, .fall_irq_req);
    // One access; read data is taken while select stands
    task automatic bus(input logic w, input logic [7:0] a, p, d);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_page <= p;
        sfr_wdata <= d;
        sfr_wr <= w;
        sfr_rd <= !w;
        @(posedge ref_clk);
        sfr_wr <= 0;
        sfr_rd <= 0;
        #1 v = sfr_rdata;
        s = sfr_sel;
    endtask
    // Reset value, every hysteresis code, read-only bit and decode misses
    task t_decode;
        bus(0, 8'h9B, 8'h00, 8'h00);
        `CHK("reset", 8'h00, v)
        `CHK("sel", 1'b1, s)
        for (int i = 0; i < 4; i++) begin
            bus(1, 8'h9B, 8'h00, {2'b11, 2'b00, 2'(i), 2'(3 - i)});
            `CHK("hyst", {2'(i), 2'(3 - i)}, {positive_hysteresis_sel, negative_hysteresis_sel})
            `CHK("enable", 1'b1, comparator_enable)
        end
        bus(0, 8'h9B, 8'h00, 8'h00);
        `CHK("ctrl", 8'h8C, v)
        bus(1, 8'h9B, 8'h01, 8'h00);
        `CHK("page", 1'b1, comparator_enable)
        bus(0, 8'h9A, 8'h00, 8'h00);
        `CHK("miss", 8'h00, v)
        `CHK("sel_miss", 1'b0, s)
    endtask
    // Both edges, the fall mask, sticky flags and software clear
    task t_edges;
        @(posedge ref_clk);
        comparator_raw <= 1;
        repeat (6) @(posedge ref_clk);
        #1 `CHK("rise_irq", 1'b1, rise_irq_req)
        `CHK("port", 1'b1, comparator_port_out)
        bus(0, 8'h9B, 8'h00, 8'h00);
        `CHK("ctrl", 8'hEC, v)
        @(posedge ref_clk);
        comparator_raw <= 0;
        repeat (6) @(posedge ref_clk);
        bus(0, 8'h9B, 8'h00, 8'h00);
        `CHK("ctrl", 8'hBC, v)
        `CHK("fall_irq", 1'b0, fall_irq_req)
        @(posedge ref_clk);
        fall_irq_mask <= 1;
        repeat (2) @(posedge ref_clk);
        #1 `CHK("fall_irq", 1'b1, fall_irq_req)
        bus(1, 8'h9B, 8'h00, 8'h0C);
        bus(0, 8'h9B, 8'h00, 8'h00);
        `CHK("clear", 8'h0C, v)
        `CHK("port", 1'b0, comparator_port_out)
    endtask
    task tally_and_finish;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial forever #25 ref_clk = ~ref_clk;
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 0;
        t_decode;
        t_edges;
        tally_and_finish;
    end
    // Run needs about 50 cycles; cut off well beyond
    initial begin
        #100000;
        n_errors++;
        tally_and_finish;
    end
endmodule
bind cmpc_control cmpc_control_checker cmpc_control_checker_inst (.ref_clk, .rst, .clk_en,
    .sfr_wr, .sfr_rd, .sfr_sel, .comparator_raw, .rise_irq_mask, .fall_irq_mask,
    .comparator_enable, .comparator_port_out, .rise_irq_req, .fall_irq_req, .sfr_addr,
    .sfr_page, .sfr_wdata, .positive_hysteresis_sel, .negative_hysteresis_sel);
